// >>> hw/timer_consts.svh
// Constants of the basic 8-bit up timer: register indices, field positions,
// reset values and the interrupt vector.
// Assumes inclusion by bare name from the basic_8bit_up_timer design module.
//
// Operation
// - The counter holds while the count-enable bit is 0 or the system is in sleep mode, and counts while it is 1 in any other mode.
// - Each prescaled timer tick outside sleep mode adds exactly one to the 8-bit tick counter, a 256-step period.
// - An overflow is seen only when a tick finds the tick counter at 0xFF, whether it wraps to 0x00 or a same-cycle write loads it.
// - Every overflow sets the overflow flag, which stays set until software clears it.
// - There is no reload buffer, so after overflow counting goes on upward from 0x00.
// - With the overflow interrupt enabled, an overflow requests the interrupt at program address 8.
// - In green mode the timer keeps counting, sets the flag on overflow and wakes the system.
// - The timer works in normal, slow and green operating modes alike.
// - The timer clock is the instruction-cycle clock through a prescaler of 2 up to 256.
// - Prescale select 000 to 111 gives divisors 256, 128, 64, 32, 16, 8, 4 and 2.
// - The mode register holds count enable in bit 7, prescale select in bits 6 to 4, and resets to 0.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define TMR_IDX_MODE      10'h0d8
`define TMR_IDX_COUNT     10'h0d9
`define TMR_IDX_STATUS    10'h0dc
`define TMR_IDX_MASK      10'h0dd

// Mode register fields and reset value; count register reset and full-scale values.
`define TMR_MODE_EN_BIT   7
`define TMR_MODE_SEL_HI   6
`define TMR_MODE_SEL_LO   4
`define TMR_MODE_RESET    8'h00
`define TMR_COUNT_RESET   8'h00
`define TMR_COUNT_FULL    8'hff

// Status and mask fields.
`define TMR_ST_OVF_BIT    0
`define TMR_ST_WAKE_BIT   1
`define TMR_ST_RESET      2'h0
`define TMR_MASK_RESET    2'h0

// Interrupt vector presented while the interrupt is pending.
`define TMR_IRQ_VECTOR    16'h0008

`endif

// >>> hw/timer_pkg.sv
// Types shared by the timer modules.
// Assumes timer_consts.svh is on the include path.
package timer_pkg;

  // System operating modes seen by the timer.
  typedef enum logic [1:0]
  {
    SYS_NORMAL,
    SYS_SLOW,
    SYS_GREEN,
    SYS_SLEEP
  } sys_mode_t;

  // Wishbone slave handshake state.
  typedef enum logic
  {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

endpackage : timer_pkg

// >>> hw/tick_if.sv
// Carrier between the timer core and its prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tick_if;

  logic       enable;
  logic [2:0] select;
  logic       cpu_tick;
  logic       tick;

  modport core
  (
    output enable,
    output select,
    output cpu_tick,
    input  tick
  );

  modport prescaler
  (
    input  enable,
    input  select,
    input  cpu_tick,
    output tick
  );

endinterface : tick_if

// >>> hw/timer_prescaler.sv
// Prescaler: divides instruction-cycle strobes down to timer ticks.
// Assumes cpu_tick is a one-cycle strobe on sys_clk.
`timescale 1ns/1ps
module timer_prescaler
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Link to the core.
  tick_if.prescaler tk
);

  typedef struct packed
  {
    logic [7:0] phase;
    logic       tick;
  } pre_state_t;

  pre_state_t st_r;
  pre_state_t st_nxt;
  logic [7:0] wrap_mask;

  // Divisor is 2 to the power of (8 - select); the mask marks the last phase.
  assign wrap_mask = 8'hff >> tk.select;

  // Next state of the divider.
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!tk.enable)
    begin
      st_nxt.phase = 8'h00;
    end
    else if (tk.cpu_tick)
    begin
      st_nxt.phase = st_r.phase + 8'h01;
      if ((st_r.phase & wrap_mask) == wrap_mask)
      begin
        st_nxt.phase = 8'h00;
        st_nxt.tick  = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tk.tick = st_r.tick;

endmodule : timer_prescaler

// >>> hw/basic_8bit_up_timer.sv
// Basic 8-bit up timer with a classic Wishbone register slave.
// Assumes a single 20 MHz sys_clk, an instruction-cycle strobe and the
// system mode coming from logic on the same clock.
`timescale 1ns/1ps
`include "timer_consts.svh"
module basic_8bit_up_timer
  import timer_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // System side.
  input  wire logic        cpu_cycle_tick,
  input  wire logic [1:0]  sys_mode,
  output logic             irq,
  output logic      [15:0] irq_vector,
  output logic             wake_req
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------

  typedef struct packed
  {
    bus_state_t  bus;
    logic [31:0] rdata;
    logic        count_enable_bit;
    logic [2:0]  prescale_select;
    logic [7:0]  tick_counter;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        irq;
    logic [15:0] vector;
    logic        wake;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  tick_if tk ();

  logic       bus_req;
  logic       wr_lane0;
  logic [9:0] reg_idx;
  logic       hit_mode;
  logic       hit_count;
  logic       hit_status;
  logic       hit_mask;
  logic       mode_ok;
  logic       step;
  logic       overflow;
  logic       in_green;
  logic [1:0] events;
  logic [1:0] status_set;
  logic [7:0] mode_rd;

  // ---------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------

  // The prescaler only runs while counting is enabled.
  assign tk.enable   = st_r.count_enable_bit;
  assign tk.select   = st_r.prescale_select;
  assign tk.cpu_tick = cpu_cycle_tick;

  timer_prescaler u_prescaler
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .tk      (tk.prescaler)
  );

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------

  // A new request is one the slave has not yet answered.
  assign bus_req    = wb_cyc_i && wb_stb_i && (st_r.bus == BUS_IDLE);
  assign wr_lane0   = bus_req && wb_we_i && wb_sel_i[0];
  assign reg_idx    = wb_adr_i[11:2];
  assign hit_mode   = (reg_idx == `TMR_IDX_MODE);
  assign hit_count  = (reg_idx == `TMR_IDX_COUNT);
  assign hit_status = (reg_idx == `TMR_IDX_STATUS);
  assign hit_mask   = (reg_idx == `TMR_IDX_MASK);

  // Mode register read image; unused low bits read as zero.
  assign mode_rd = {st_r.count_enable_bit, st_r.prescale_select, 4'h0};

  // ---------------------------------------------------------------------
  // Counting and events
  // ---------------------------------------------------------------------

  // Power-down stops the clock tree; all other modes keep the timer alive.
  assign mode_ok = (sys_mode != SYS_SLEEP);
  assign in_green = (sys_mode == SYS_GREEN);

  // A counter step needs enable, a prescaled tick and a live mode.
  assign step = st_r.count_enable_bit && tk.tick && mode_ok;

  // Only a step taken at full scale counts as an overflow, whether it wraps to zero or a same-cycle write loads the counter.
  assign overflow = step && (st_r.tick_counter == `TMR_COUNT_FULL);

  // Event vector in status layout: overflow and green-mode wake.
  always_comb
  begin
    events                   = 2'h0;
    events[`TMR_ST_OVF_BIT]  = overflow;
    events[`TMR_ST_WAKE_BIT] = overflow && in_green;
  end

  assign status_set = events;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------

  // Fill the next copy of the whole state.
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.wake  = 1'b0;

    // Bus handshake: answer every request one cycle after it is seen.
    unique case (st_r.bus)
      BUS_IDLE:
      begin
        if (bus_req)
        begin
          st_nxt.bus   = BUS_ACK;
          st_nxt.rdata = 32'h0000_0000;
          if (hit_mode)
          begin
            st_nxt.rdata[7:0] = mode_rd;
          end
          else if (hit_count)
          begin
            st_nxt.rdata[7:0] = st_r.tick_counter;
          end
          else if (hit_status)
          begin
            st_nxt.rdata[1:0] = st_r.status;
          end
          else if (hit_mask)
          begin
            st_nxt.rdata[1:0] = st_r.mask;
          end
        end
      end
      BUS_ACK:
      begin
        st_nxt.bus = BUS_IDLE;
      end
    endcase

    // Mode register write; all fields take effect at once.
    if (wr_lane0 && hit_mode)
    begin
      st_nxt.count_enable_bit = wb_dat_i[`TMR_MODE_EN_BIT];
      st_nxt.prescale_select  = wb_dat_i[`TMR_MODE_SEL_HI:`TMR_MODE_SEL_LO];
    end

    // Tick counter: a software write beats a step in the same cycle.
    if (wr_lane0 && hit_count)
    begin
      st_nxt.tick_counter = wb_dat_i[7:0];
    end
    else if (step)
    begin
      // Plain wrap to zero, nothing is reloaded.
      st_nxt.tick_counter = st_r.tick_counter + 8'h01;
    end

    // Status: write one to clear, but a new event always wins.
    if (wr_lane0 && hit_status)
    begin
      st_nxt.status = st_r.status & ~wb_dat_i[1:0];
    end
    st_nxt.status = st_nxt.status | status_set;

    // Mask register; the overflow bit is the overflow interrupt enable.
    if (wr_lane0 && hit_mask)
    begin
      st_nxt.mask = wb_dat_i[1:0];
    end

    // Level interrupt while any unmasked status bit is set.
    st_nxt.irq    = |(st_nxt.status & st_nxt.mask);
    st_nxt.vector = st_nxt.irq ? `TMR_IRQ_VECTOR : 16'h0000;

    // One-cycle wake request on overflow in green mode.
    st_nxt.wake = events[`TMR_ST_WAKE_BIT];
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------

  // All control state returns to zero on reset.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r                  <= '0;
      st_r.bus              <= BUS_IDLE;
      st_r.count_enable_bit <= 1'(`TMR_MODE_RESET >> `TMR_MODE_EN_BIT);
      st_r.tick_counter     <= `TMR_COUNT_RESET;
      st_r.status           <= `TMR_ST_RESET;
      st_r.mask             <= `TMR_MASK_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------

  // Every output is a field of the state register.
  assign wb_ack_o   = (st_r.bus == BUS_ACK);
  assign wb_dat_o   = st_r.rdata;
  assign irq        = st_r.irq;
  assign irq_vector = st_r.vector;
  assign wake_req   = st_r.wake;

endmodule : basic_8bit_up_timer

// >>> tb/timer_assertions.sv
// Concurrent checks on the timer's bus and event pins.
// Assumes it is bound to basic_8bit_up_timer.
`timescale 1ns/1ps
module timer_chk
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // Bus and system pins.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  sys_mode,
  input wire logic        irq,
  input wire logic [15:0] irq_vector,
  input wire logic        wake_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ----------
  // Bus steps.
  // ----------
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_answer_a: assert property (bus_req |=> ack_once)
    else $error("ack not one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  mode_unused_a: assert property (wb_ack_o && $past(wb_adr_i[11:2] == 10'h0d8 && !wb_we_i)
    |-> wb_dat_o[3:0] == 4'h0) else $error("mode low bits set");
  // Interrupt and wake pins.
  vector_tie_a: assert property (irq_vector == (irq ? 16'h0008 : 16'h0000))
    else $error("vector mismatch");
  irq_hold_a: assert property ($fell(irq) |-> $past(wb_we_i && wb_stb_i)
    || $past(wb_we_i && wb_stb_i, 2)) else $error("irq fell without write");
  wake_green_a: assert property (wake_req |-> $past(sys_mode) == 2'h2)
    else $error("wake outside green");
  wake_pulse_a: assert property (wake_req |=> !wake_req)
    else $error("wake too long");
endmodule : timer_chk

bind basic_8bit_up_timer timer_chk u_chk (.sys_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .sys_mode, .irq, .irq_vector, .wake_req);

// >>> tb/basic_8bit_up_timer_tb.sv
// Self-checking bench: integer model of the timer against the design.
// Assumes the design and checker are compiled before it.
`timescale 1ns/1ps
module basic_8bit_up_timer_tb;
  // ----------
  // Signals.
  // ----------
  logic        sys_clk, arst_n, cyc, stb, we, tick, irq, wake, ack;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, got;
  logic [1:0]  mode;
  logic [15:0] vec;
  logic [7:0]  seed;
  int          bad_count, n_tests, cycles, wakes, exp_wakes, m_cnt, m_st, m_mask, div, ph;

  basic_8bit_up_timer u_dut
  (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cpu_cycle_tick(tick), .sys_mode(mode), .irq(irq), .irq_vector(vec), .wake_req(wake)
  );

  // Clock of 50 ns.
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Hang limit and wake pulse counter.
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (cycles == 30000)
    begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One classic cycle, started right after a rising edge; the request stands until ack is
  // sampled high at a rising edge, read data is taken at that edge, then one idle cycle.
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    @(posedge sys_clk);
    while (ack !== 1'b1) @(posedge sys_clk);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp, input string nm);
    bus(1'b0, idx, 8'h00);
    chk(nm, {24'h0, exp}, got);
  endtask : rd

  // Strobes with random gaps; the model steps only while counting.
  task automatic pulse(input int n, input bit on);
    repeat (n)
    begin
      @(posedge sys_clk);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
      repeat (seed[1:0]) @(posedge sys_clk);
      seed = lfsr(seed);
      if (on && ++ph == div)
      begin
        ph = 0;
        // Sleep freezes the counter; normal, slow and green keep it running.
        if (mode != 2'h3)
        begin
          m_cnt = (m_cnt + 1) % 256;
          if (m_cnt == 0) m_st = m_st | (mode == 2'h2 ? 3 : 1);
          if (m_cnt == 0 && mode == 2'h2) exp_wakes++;
        end
      end
    end
  endtask : pulse

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // Main sequence.
  initial
  begin
    arst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h1;
    wdat = 32'h0; tick = 1'b0; mode = 2'h0; seed = 8'h23;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(10'h0d8, 8'h00, "mode");
    rd(10'h0d9, 8'h00, "count");
    rd(10'h0dc, 8'h00, "status");
    rd(10'h0e0, 8'h00, "unmapped");
    // A write with lane 0 disabled is acked but leaves the register alone.
    sel <= 4'h0;
    bus(1'b1, 10'h0d9, 8'h55);
    sel <= 4'h1;
    rd(10'h0d9, 8'h00, "sel off");
    bus(1'b1, 10'h0d8, 8'h7f);
    rd(10'h0d8, 8'h70, "mode bits");
    for (int s = 0; s < 8; s++)
    begin
      div = 256 >> s;
      mode <= 2'(s % 4);
      m_mask = (s + 1) % 4;
      bus(1'b1, 10'h0dd, 8'(m_mask));
      bus(1'b1, 10'h0d8, 8'(s << 4));
      bus(1'b1, 10'h0d9, 8'hfe);
      pulse(5, 1'b0);
      bus(1'b1, 10'h0d8, 8'(8'h80 | (s << 4)));
      m_cnt = 254;
      m_st = 0;
      ph = 0;
      pulse(3 * div + seed % div, 1'b1);
      repeat (4) @(posedge sys_clk);
      bus(1'b1, 10'h0d8, 8'(s << 4));
      rd(10'h0d9, 8'(m_cnt), "count");
      rd(10'h0dc, 8'(m_st), "status");
      chk("irq", (m_st & m_mask) != 0 ? 1 : 0, {31'h0, irq});
      chk("vector", (m_st & m_mask) != 0 ? 32'h8 : 32'h0, {16'h0, vec});
      bus(1'b1, 10'h0dc, 8'h03);
      rd(10'h0dc, 8'h00, "status clear");
      chk("irq clear", 0, {31'h0, irq});
    end
    chk("wakes", exp_wakes, wakes);
    test_done();
  end
endmodule : basic_8bit_up_timer_tb
